// File: bclim_pkg.sv
package bclim_pkg;
    localparam int unsigned REG_W = 8;
    localparam int unsigned NCONV = 3;
    localparam logic [7:0] OFF_CATEGORY = 8'h06;
    localparam logic [7:0] OFF_LS_STATUS = 8'h08;
    localparam logic [7:0] OFF_LS_MASK = 8'h09;
    localparam logic [7:0] OFF_LS_SENSE = 8'h0a;
    localparam logic [7:0] OFF_HS_STATUS = 8'h0b;
    localparam logic [7:0] OFF_HS_MASK = 8'h0c;
    localparam logic [7:0] OFF_HS_SENSE = 8'h0d;
    localparam int unsigned CAT_CONV_LSB = 1;
    localparam logic [2:0] MASK_RST = 3'h7;
    localparam logic [2:0] STATUS_RST = 3'h0;
    localparam logic [2:0] SENSE_RST = 3'h0;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned DEBOUNCE_NS = 1000;
    localparam int unsigned SWITCH_PERIOD_NS = 500;
    localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SWITCH_CYC = SWITCH_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 6;
    localparam logic [CNT_W-1:0] DEBOUNCE_LAST = CNT_W'(DEBOUNCE_CYC);
    localparam logic [CNT_W-1:0] SWITCH_LAST = CNT_W'(SWITCH_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
endpackage

// File: bclim_fault_filter.sv
`timescale 1ns/1ps
module bclim_fault_filter
    import bclim_pkg::*;
#(
    parameter bit WINDOWED = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic fault_i,
    input wire logic tick_i,
    output logic live_o
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic seen_reg;
    logic seen_next;
    logic live_reg;
    logic live_next;

    always_comb begin
        cnt_next = cnt_reg;
        seen_next = seen_reg;
        live_next = live_reg;
        if (WINDOWED) begin
            // Any fault seen in the switching cycle is reported at its end
            seen_next = seen_reg | fault_i;
            if (tick_i) begin
                live_next = seen_reg | fault_i;
                seen_next = 1'b0;
            end
        end else begin
            if (!fault_i) begin
                cnt_next = CNT_ZERO;
                live_next = 1'b0;
            end else if (cnt_reg == DEBOUNCE_LAST) begin
                live_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + CNT_ONE;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= CNT_ZERO;
            seen_reg <= 1'b0;
            live_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            seen_reg <= seen_next;
            live_reg <= live_next;
        end
    end

    assign live_o = live_reg;
endmodule

// File: bclim_irq_regs.sv
// Notes on behaviour
// - Low-side status bit sets only after fault outlasts debounce; bits 1,2 converters 2,3.
// - Status bits stay set until cleared by reading or writing one.
// - Unmasked set status bit drives the interrupt pin low.
// - Masked status bit still latches but never pulls the pin low.
// - All six mask bits reset to one.
// - Low-side sense bits 0..2 at 0x0A follow debounced fault; reset zero.
// - High-side sense reports per switching cycle, toggling at most once per cycle.
// - High-side status bits 0..2 at 0x0B reset zero; bits 7..3 unused.
// - Low-side masks at 0x09, high-side masks at 0x0C, bits 0..2, read-write.
// - High-side sense bit 0 at 0x0D follows fault; resets zero.
// - Low-side status bit 0 at 0x08, read or write-one clears.
// - Category summary bit per converter reads one if any its status set.
`timescale 1ns/1ps
module bclim_irq_regs
    import bclim_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [2:0] ls_fault_i,
    input wire logic [2:0] hs_fault_i,
    output logic [7:0] reg_rdata_o,
    output logic irq_out_n_o
);
    logic [CNT_W-1:0] sw_cnt_reg;
    logic [CNT_W-1:0] sw_cnt_next;
    logic sw_tick_reg;
    logic sw_tick_next;
    logic [2:0] ls_live;
    logic [2:0] hs_live;
    logic [2:0] ls_live_d_reg;
    logic [2:0] hs_live_d_reg;
    logic [2:0] ls_rise;
    logic [2:0] hs_rise;
    logic [2:0] ls_clr;
    logic [2:0] hs_clr;
    logic [2:0] lowside_limit_status_reg;
    logic [2:0] lowside_limit_status_next;
    logic [2:0] highside_limit_status_reg;
    logic [2:0] highside_limit_status_next;
    logic [2:0] lowside_limit_mask_reg;
    logic [2:0] lowside_limit_mask_next;
    logic [2:0] highside_limit_mask_reg;
    logic [2:0] highside_limit_mask_next;
    logic [2:0] conv_summary;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic irq_n_reg;
    logic irq_n_next;

    // Switching-cycle enable for the high-side sense window
    always_comb begin
        sw_tick_next = (sw_cnt_reg == SWITCH_LAST);
        sw_cnt_next = sw_tick_next ? CNT_ZERO : sw_cnt_reg + CNT_ONE;
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sw_cnt_reg <= CNT_ZERO;
            sw_tick_reg <= 1'b0;
        end else begin
            sw_cnt_reg <= sw_cnt_next;
            sw_tick_reg <= sw_tick_next;
        end
    end

    for (genvar i = 0; i < NCONV; i++) begin : g_conv
        bclim_fault_filter #(.WINDOWED(1'b0)) u_ls (
            .core_clk_i(core_clk_i),
            .sys_rst_i(sys_rst_i),
            .fault_i(ls_fault_i[i]),
            .tick_i(1'b1),
            .live_o(ls_live[i])
        );
        bclim_fault_filter #(.WINDOWED(1'b1)) u_hs (
            .core_clk_i(core_clk_i),
            .sys_rst_i(sys_rst_i),
            .fault_i(hs_fault_i[i]),
            .tick_i(sw_tick_reg),
            .live_o(hs_live[i])
        );
    end

    // Status, mask, interrupt pin and read data
    always_comb begin
        ls_rise = ls_live & ~ls_live_d_reg;
        hs_rise = hs_live & ~hs_live_d_reg;
        ls_clr = 3'h0;
        hs_clr = 3'h0;
        lowside_limit_mask_next = lowside_limit_mask_reg;
        highside_limit_mask_next = highside_limit_mask_reg;
        if (reg_rd_i && reg_addr_i == OFF_LS_STATUS) begin
            ls_clr = lowside_limit_status_reg;
        end
        if (reg_rd_i && reg_addr_i == OFF_HS_STATUS) begin
            hs_clr = highside_limit_status_reg;
        end
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                OFF_LS_STATUS: ls_clr = ls_clr | reg_wdata_i[2:0];
                OFF_HS_STATUS: hs_clr = hs_clr | reg_wdata_i[2:0];
                OFF_LS_MASK: lowside_limit_mask_next = reg_wdata_i[2:0];
                OFF_HS_MASK: highside_limit_mask_next = reg_wdata_i[2:0];
                default: ;
            endcase
        end
        // A new fault wins over a clear in the same cycle so no event is lost
        lowside_limit_status_next = (lowside_limit_status_reg & ~ls_clr) | ls_rise;
        highside_limit_status_next = (highside_limit_status_reg & ~hs_clr) | hs_rise;
        // Masked bits still latch above; only the pin ignores them
        irq_n_next = ~|((lowside_limit_status_next & ~lowside_limit_mask_next)
                      | (highside_limit_status_next & ~highside_limit_mask_next));
        conv_summary = lowside_limit_status_reg | highside_limit_status_reg;
        rdata_next = RDATA_RST;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFF_CATEGORY: rdata_next = REG_W'(conv_summary) << CAT_CONV_LSB;
                OFF_LS_STATUS: rdata_next = REG_W'(lowside_limit_status_reg);
                OFF_LS_MASK: rdata_next = REG_W'(lowside_limit_mask_reg);
                OFF_LS_SENSE: rdata_next = REG_W'(ls_live);
                OFF_HS_STATUS: rdata_next = REG_W'(highside_limit_status_reg);
                OFF_HS_MASK: rdata_next = REG_W'(highside_limit_mask_reg);
                OFF_HS_SENSE: rdata_next = REG_W'(hs_live);
                default: rdata_next = RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ls_live_d_reg <= SENSE_RST;
            hs_live_d_reg <= SENSE_RST;
            lowside_limit_status_reg <= STATUS_RST;
            highside_limit_status_reg <= STATUS_RST;
            lowside_limit_mask_reg <= MASK_RST;
            highside_limit_mask_reg <= MASK_RST;
            rdata_reg <= RDATA_RST;
            irq_n_reg <= 1'b1;
        end else begin
            ls_live_d_reg <= ls_live;
            hs_live_d_reg <= hs_live;
            lowside_limit_status_reg <= lowside_limit_status_next;
            highside_limit_status_reg <= highside_limit_status_next;
            lowside_limit_mask_reg <= lowside_limit_mask_next;
            highside_limit_mask_reg <= highside_limit_mask_next;
            rdata_reg <= rdata_next;
            irq_n_reg <= irq_n_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign irq_out_n_o = irq_n_reg;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Fault still present on the last two counted edges of the debounce
    sequence fault0_held;
        (ls_fault_i[0] && g_conv[0].u_ls.cnt_reg == DEBOUNCE_LAST - CNT_ONE) ##1 ls_fault_i[0];
    endsequence

    AST_IRQ_TRACKS_STATUS: assert property (
        irq_out_n_o == !(|((lowside_limit_status_reg & ~lowside_limit_mask_reg)
                         | (highside_limit_status_reg & ~highside_limit_mask_reg))))
        else $error("Interrupt pin disagrees with unmasked status");
    AST_MASKED_QUIET: assert property (
        (&lowside_limit_mask_reg && &highside_limit_mask_reg) |-> irq_out_n_o)
        else $error("Masked status pulled the pin low");
    AST_MASK_RESET: assert property (
        $fell(sys_rst_i) |-> (lowside_limit_mask_reg == MASK_RST
                              && highside_limit_mask_reg == MASK_RST))
        else $error("Mask bits not one after reset");
    AST_LS_DEBOUNCE: assert property (
        $rose(ls_live[0]) |-> $past(ls_fault_i[0] && g_conv[0].u_ls.cnt_reg == DEBOUNCE_LAST))
        else $error("Low-side sense rose without a held fault");
    AST_LS_SETS: assert property (
        fault0_held |=> $rose(ls_live[0]))
        else $error("Low-side sense missed a fault that outlasted the debounce");
    AST_LS_LATCH: assert property (
        (ls_rise != 3'h0) |=> ((lowside_limit_status_reg & $past(ls_rise)) == $past(ls_rise)))
        else $error("Low-side status did not latch");
    AST_STICKY: assert property (
        (lowside_limit_status_reg != 3'h0) && !reg_wr_i && !reg_rd_i |=>
        ((lowside_limit_status_reg & $past(lowside_limit_status_reg))
         == $past(lowside_limit_status_reg)))
        else $error("Status bit dropped without a clear");
    AST_SENSE_DROP: assert property (
        !ls_fault_i[1] |=> !ls_live[1])
        else $error("Low-side sense held after fault removed");
    AST_HS_PACED: assert property (
        $changed(hs_live) |-> $past(sw_tick_reg))
        else $error("High-side sense changed inside a switching cycle");
    AST_UNUSED_ZERO: assert property (
        reg_rd_i && reg_addr_i >= OFF_LS_STATUS && reg_addr_i <= OFF_HS_SENSE
        |=> reg_rdata_o[7:3] == 5'h00)
        else $error("Unused bits read nonzero");
    AST_SUMMARY_READ: assert property (
        reg_rd_i && reg_addr_i == OFF_CATEGORY |=>
        reg_rdata_o[3:1] == $past(lowside_limit_status_reg | highside_limit_status_reg))
        else $error("Category summary wrong");
endmodule

// File: bclim_host.sv
`timescale 1ns/1ps
module bclim_host (
    input wire logic core_clk_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o
);
    initial begin
        reg_addr_o = 8'h5a;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'ha5;
        reg_rd_o = 1'b0;
    end
    // Idle bus shows inverted leftovers, so a stale address never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1 d = reg_rdata_i;
    endtask
endmodule

// File: test_buck_current_limit_irq_regs.sv
`timescale 1ns/1ps
module test_buck_current_limit_irq_regs;
    import bclim_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] ls_fault_i = 3'h0;
    logic [2:0] hs_fault_i = 3'h0;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic [7:0] reg_rdata_o;
    logic reg_wr_i;
    logic reg_rd_i;
    logic irq_out_n_o;
    int num_errors = 0;
    int comparisons = 0;
    int sts[2];
    int msk[2];
    logic [7:0] rv;
    logic [7:0] rst_off[7] = '{OFF_CATEGORY, OFF_LS_STATUS, OFF_LS_MASK, OFF_LS_SENSE,
        OFF_HS_STATUS, OFF_HS_MASK, OFF_HS_SENSE};
    logic [7:0] rst_val[7] = '{8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h07, 8'h00};
    logic [7:0] st_off[2] = '{OFF_LS_STATUS, OFF_HS_STATUS};
    logic [7:0] mk_off[2] = '{OFF_LS_MASK, OFF_HS_MASK};
    logic [7:0] se_off[2] = '{OFF_LS_SENSE, OFF_HS_SENSE};
    always #12.5 core_clk_i = ~core_clk_i;
    bclim_irq_regs DUT (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i), .ls_fault_i(ls_fault_i), .hs_fault_i(hs_fault_i),
        .reg_rdata_o(reg_rdata_o), .irq_out_n_o(irq_out_n_o));
    bclim_host host (.core_clk_i(core_clk_i), .reg_rdata_i(reg_rdata_o),
        .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i),
        .reg_rd_o(reg_rd_i));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string name);
        host.rd(a, rv);
        chk(name, rv, exp);
    endtask
    // Pin is high unless some latched status is left unmasked
    task automatic irqchk();
        logic e;
        e = ((((sts[0] & ~msk[0]) | (sts[1] & ~msk[1])) & 7) == 0);
        chk("irq_out_n", {7'h0, irq_out_n_o}, {7'h0, e});
    endtask
    task automatic end_of_test();
        $display("Errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk_i);
        num_errors++;
        end_of_test();
    end
    initial begin
        int i;
        int s;
        logic [7:0] wd;
        void'($urandom(32'h0360));
        repeat (10) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        sts = '{0, 0};
        msk = '{7, 7};
        for (int k = 0; k < 7; k++) begin
            rchk(rst_off[k], rst_val[k], "reset_value");
        end
        irqchk();
        host.wr(OFF_LS_SENSE, 8'hff);
        host.wr(OFF_HS_SENSE, 8'hff);
        host.wr(OFF_CATEGORY, 8'hff);
        rchk(8'h20, 8'h00, "unmapped");
        rchk(OFF_LS_SENSE, 8'h00, "ls_sense_ro");
        rchk(OFF_HS_SENSE, 8'h00, "hs_sense_ro");
        rchk(OFF_CATEGORY, 8'h00, "category_ro");
        // A fault that does not outlast the debounce must leave no trace
        host.wr(OFF_LS_MASK, 8'h00);
        msk[0] = 0;
        @(posedge core_clk_i);
        ls_fault_i <= 3'h7;
        repeat ($urandom_range(DEBOUNCE_CYC, 5)) @(posedge core_clk_i);
        ls_fault_i <= 3'h0;
        repeat (5) @(posedge core_clk_i);
        rchk(OFF_LS_STATUS, 8'h00, "ls_glitch");
        irqchk();
        for (int j = 0; j < 6; j++) begin
            i = j % 3;
            s = j / 3;
            wd = 8'($urandom);
            wd[i] = j[0];
            host.wr(mk_off[s], wd);
            msk[s] = wd & 7;
            rchk(mk_off[s], 8'(msk[s]), "mask");
            @(posedge core_clk_i);
            if (s == 0) begin
                ls_fault_i[i] <= 1'b1;
            end else begin
                hs_fault_i[i] <= 1'b1;
            end
            repeat (50) @(posedge core_clk_i);
            sts[s] = 1 << i;
            rchk(se_off[s], 8'(1 << i), "sense");
            irqchk();
            rchk(OFF_CATEGORY, 8'(2 << i), "category");
            host.wr(st_off[s], 8'h00);
            irqchk();
            if (j[0]) begin
                host.wr(st_off[s], 8'(1 << i));
                sts[s] = 0;
            end
            rchk(st_off[s], 8'(sts[s]), "status");
            sts[s] = 0;
            rchk(st_off[s], 8'h00, "status_cleared");
            irqchk();
            @(posedge core_clk_i);
            ls_fault_i <= 3'h0;
            hs_fault_i <= 3'h0;
            repeat (45) @(posedge core_clk_i);
            rchk(se_off[s], 8'h00, "sense_gone");
        end
        // Reset in mid-run with an unmasked status pending
        host.wr(OFF_LS_MASK, 8'h00);
        msk[0] = 0;
        @(posedge core_clk_i);
        ls_fault_i <= 3'h1;
        repeat (50) @(posedge core_clk_i);
        sts[0] = 1;
        irqchk();
        @(posedge core_clk_i);
        ls_fault_i <= 3'h0;
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        sts = '{0, 0};
        msk = '{7, 7};
        rchk(OFF_LS_STATUS, 8'h00, "status_rerst");
        irqchk();
        rchk(OFF_LS_MASK, 8'h07, "mask_rerst");
        rchk(OFF_HS_MASK, 8'h07, "mask_rerst");
        end_of_test();
    end
endmodule
